//--- lcd_dev.sv
`timescale 1ns/10ps
// Operation
// - Pump-off bit five stops charge pump
// - Host sets pump-off without series switch
// - Clearing pump-off while running forces shutdown
// - Bits zero-four disable sinks two-six
// - Sink disables written before global run
// - Fade enable bit three enables fading
// - Gain bit four: 12.5% or 6.25%
// - Interval bits 2:0 give 2^n cycles (codes six and seven clamp to 32)
// - Host uses interval codes zero to five
// - Low-dim status reports channels one-six
// - Open flags set per channel, read-clear
// - Ground-short flags set per channel, read-clear
module lcd_dev (
   input wire logic core_clk,
   input wire logic reset_n,
   lcd_if.dev bus,
   input wire logic global_run,
   input wire logic dim_cycle,
   input wire logic [5:0] lowdim_in,
   input wire logic [5:0] open_evt,
   input wire logic [5:0] gnd_short_evt,
   output logic series_switch_gate,
   output logic [5:0] sink_on,
   output logic shutdown,
   output logic fade_en,
   output logic [1:0] fade_step,
   output logic fade_tick
);
   logic [7:0] ctrl_ff;
   logic [7:0] fade_ff;
   logic [5:0] open_ff;
   logic [5:0] gnd_ff;
   logic [5:0] lowdim_ff;
   logic shut_ff;
   logic [4:0] tick_cnt_ff;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic rd_open;
   logic rd_gnd;
   logic [4:0] period_mask;
   logic [4:0] sel_wr;
   logic [4:0] sel_rd;
   logic pump_restart;
   logic [7:0] rd_word;

   // Select bit of each register in the one-hot decode
   localparam int SEL_CTRL = 0;
   localparam int SEL_FADE = 1;
   localparam int SEL_LOWDIM = 2;
   localparam int SEL_OPEN = 3;
   localparam int SEL_GND = 4;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Shared by the write, read and read-clear paths so they never disagree
   function automatic logic [4:0] reg_sel(input logic [7:0] addr);
      logic [4:0] sel;
      sel = 5'h00;
      if (addr == lcd_pkg::ADDR_CHANNEL_DISABLE_CTRL) begin
         sel[SEL_CTRL] = 1'h1;
      end else if (addr == lcd_pkg::ADDR_FADE_CONFIG) begin
         sel[SEL_FADE] = 1'h1;
      end else if (addr == lcd_pkg::ADDR_LOW_DIM_STATUS) begin
         sel[SEL_LOWDIM] = 1'h1;
      end else if (addr == lcd_pkg::ADDR_OPEN_STRING_FLAGS) begin
         sel[SEL_OPEN] = 1'h1;
      end else if (addr == lcd_pkg::ADDR_SHORT_GROUND_FLAGS) begin
         sel[SEL_GND] = 1'h1;
      end
      return sel;
   endfunction

   assign sel_wr = bus.wr_stb ? reg_sel(bus.addr) : 5'h00;
   assign sel_rd = bus.rd_stb ? reg_sel(bus.addr) : 5'h00;

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= lcd_pkg::RST_REG;
      end else if (sel_wr[SEL_CTRL]) begin
         ctrl_ff <= bus.wdata & lcd_pkg::LIVE_MASK_CTRL;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fade_ff <= lcd_pkg::RST_REG;
      end else if (sel_wr[SEL_FADE]) begin
         fade_ff <= bus.wdata & lcd_pkg::LIVE_MASK_FADE;
      end
   end

   // Pump turned back on while running latches a shutdown until reset
   assign pump_restart = sel_wr[SEL_CTRL] && global_run && ctrl_ff[lcd_pkg::POS_PUMP_OFF]
                         && !bus.wdata[lcd_pkg::POS_PUMP_OFF];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         shut_ff <= 1'h0;
      end else if (pump_restart) begin
         shut_ff <= 1'h1;
      end
   end

   assign shutdown = shut_ff;
   assign series_switch_gate = !ctrl_ff[lcd_pkg::POS_PUMP_OFF] && !shut_ff;
   assign sink_on = shut_ff ? 6'h00 : {~ctrl_ff[lcd_pkg::POS_SINK_OFF_HI:lcd_pkg::POS_SINK_OFF_LO], 1'b1};
   assign fade_en = fade_ff[lcd_pkg::POS_FADE_EN];
   assign fade_step = fade_ff[lcd_pkg::POS_FADE_GAIN] ? lcd_pkg::STEP_HIGH_GAIN
                                                      : lcd_pkg::STEP_LOW_GAIN;

   // ----------------------------------------
   // Fade update tick
   // ----------------------------------------
   // Codes above five are clamped to the longest period
   always_comb begin
      logic [2:0] code;
      code = fade_ff[lcd_pkg::POS_INTERVAL_HI:lcd_pkg::POS_INTERVAL_LO];
      if (code > lcd_pkg::INTERVAL_MAX) begin
         code = lcd_pkg::INTERVAL_MAX;
      end
      period_mask = 5'(({5'h00, 1'b1} << code) - 6'h01);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_ff <= 5'h00;
      end else if (dim_cycle) begin
         tick_cnt_ff <= ((tick_cnt_ff & period_mask) == period_mask) ? 5'h00 : tick_cnt_ff + 5'h01;
      end
   end

   assign fade_tick = fade_en && dim_cycle && ((tick_cnt_ff & period_mask) == period_mask);

   // ----------------------------------------
   // Status and fault flags
   // ----------------------------------------
   assign rd_open = sel_rd[SEL_OPEN];
   assign rd_gnd = sel_rd[SEL_GND];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lowdim_ff <= 6'h00;
      end else begin
         lowdim_ff <= lowdim_in;
      end
   end

   // A new event wins over a read clear in the same cycle, so no fault is lost
   for (genvar ch = 0; ch < lcd_pkg::NUM_CH; ch++) begin : g_flag
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            open_ff[ch] <= 1'h0;
         end else if (open_evt[ch]) begin
            open_ff[ch] <= 1'h1;
         end else if (rd_open) begin
            open_ff[ch] <= 1'h0;
         end
      end

      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            gnd_ff[ch] <= 1'h0;
         end else if (gnd_short_evt[ch]) begin
            gnd_ff[ch] <= 1'h1;
         end else if (rd_gnd) begin
            gnd_ff[ch] <= 1'h0;
         end
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Unmapped addresses read as zero; unused top bits are zero in every word
   always_comb begin
      rd_word = lcd_pkg::READ_NONE;
      if (sel_rd[SEL_CTRL]) begin
         rd_word = ctrl_ff;
      end else if (sel_rd[SEL_FADE]) begin
         rd_word = fade_ff;
      end else if (sel_rd[SEL_LOWDIM]) begin
         rd_word = {2'h0, lowdim_ff};
      end else if (sel_rd[SEL_OPEN]) begin
         rd_word = {2'h0, open_ff};
      end else if (sel_rd[SEL_GND]) begin
         rd_word = {2'h0, gnd_ff};
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_ff <= 1'h0;
      end else begin
         rvalid_ff <= bus.rd_stb;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff <= lcd_pkg::READ_NONE;
      end else if (bus.rd_stb) begin
         rdata_ff <= rd_word;
      end
   end

   assign bus.rdata = rdata_ff;
   assign bus.rvalid = rvalid_ff;
endmodule

//--- lcd_pkg.sv
package lcd_pkg;
   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_CHANNEL_DISABLE_CTRL = 8'h14;
   localparam logic [7:0] ADDR_FADE_CONFIG = 8'h15;
   localparam logic [7:0] ADDR_LOW_DIM_STATUS = 8'h16;
   localparam logic [7:0] ADDR_OPEN_STRING_FLAGS = 8'h17;
   localparam logic [7:0] ADDR_SHORT_GROUND_FLAGS = 8'h18;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int POS_PUMP_OFF = 5;
   localparam int POS_SINK_OFF_LO = 0;
   localparam int POS_SINK_OFF_HI = 4;
   localparam int POS_FADE_GAIN = 4;
   localparam int POS_FADE_EN = 3;
   localparam int POS_INTERVAL_HI = 2;
   localparam int POS_INTERVAL_LO = 0;
   localparam int NUM_CH = 6;
   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] LIVE_MASK_CTRL = 8'h3F;
   localparam logic [7:0] LIVE_MASK_FADE = 8'h1F;
   localparam logic [2:0] INTERVAL_MAX = 3'h5;
   // Fade step in 1/16ths of a unit: 6.25% = 1, 12.5% = 2
   localparam logic [1:0] STEP_LOW_GAIN = 2'h1;
   localparam logic [1:0] STEP_HIGH_GAIN = 2'h2;
   localparam logic [7:0] READ_NONE = 8'h00;
endpackage

//--- lcd_if.sv
`timescale 1ns/10ps
interface lcd_if;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   modport dev (input wr_stb, input rd_stb, input addr, input wdata, output rdata, output rvalid);
   modport host (output wr_stb, output rd_stb, output addr, output wdata, input rdata, input rvalid);
endinterface

//--- lcd_host.sv
`timescale 1ns/10ps
module lcd_host (
   input wire logic core_clk,
   input wire logic reset_n,
   lcd_if.host bus,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic global_run,
   output logic req_ready,
   output logic [7:0] resp_data,
   output logic resp_valid,
   output logic req_refused
);
   typedef enum logic [1:0] {
      LCDH_IDLE = 2'b01,
      LCDH_WAIT = 2'b10
   } lcdh_state_t;

   lcdh_state_t state_ff;
   logic wr_ff;
   logic rd_ff;
   logic [7:0] addr_ff;
   logic [7:0] wdata_ff;
   logic [7:0] resp_ff;
   logic resp_v_ff;
   logic ref_ff;
   logic bad;

   // ----------------------------------------
   // Request screening
   // ----------------------------------------
   // Control writes while running and fade writes with interval codes above five are refused
   always_comb begin
      bad = 1'b0;
      if (req_write && req_addr == lcd_pkg::ADDR_CHANNEL_DISABLE_CTRL && global_run) begin
         bad = 1'b1;
      end
      if (req_write && req_addr == lcd_pkg::ADDR_FADE_CONFIG
          && req_wdata[lcd_pkg::POS_INTERVAL_HI:lcd_pkg::POS_INTERVAL_LO] > lcd_pkg::INTERVAL_MAX) begin
         bad = 1'b1;
      end
   end

   assign req_ready = (state_ff == LCDH_IDLE);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= LCDH_IDLE;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         addr_ff <= 8'h00;
         wdata_ff <= 8'h00;
         ref_ff <= 1'b0;
      end else begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         ref_ff <= 1'b0;
         case (state_ff)
            LCDH_IDLE: begin
               if (req_valid && bad) begin
                  ref_ff <= 1'b1;
               end else if (req_valid) begin
                  wr_ff <= req_write;
                  rd_ff <= !req_write;
                  addr_ff <= req_addr;
                  wdata_ff <= req_write ? req_wdata : 8'h00;
                  state_ff <= req_write ? LCDH_IDLE : LCDH_WAIT;
               end
            end
            LCDH_WAIT: begin
               if (bus.rvalid) begin
                  state_ff <= LCDH_IDLE;
               end
            end
            default: begin
               state_ff <= LCDH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         resp_ff <= 8'h00;
         resp_v_ff <= 1'b0;
      end else begin
         resp_v_ff <= bus.rvalid && state_ff == LCDH_WAIT;
         if (bus.rvalid && state_ff == LCDH_WAIT) begin
            resp_ff <= bus.rdata;
         end
      end
   end

   assign bus.wr_stb = wr_ff;
   assign bus.rd_stb = rd_ff;
   assign bus.addr = addr_ff;
   assign bus.wdata = wdata_ff;
   assign resp_data = resp_ff;
   assign resp_valid = resp_v_ff;
   assign req_refused = ref_ff;
endmodule

//--- lcd_properties.sv
`timescale 1ns/10ps
module lcd_properties (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence rd_at(logic [7:0] a);
      rd_stb && addr == a;
   endsequence
   read_answer_a: assert property (rd_stb |=> rvalid) else $error("read not answered");
   answer_cause_a: assert property (rvalid |-> $past(rd_stb)) else $error("stray read answer");
   answer_pulse_a: assert property (rvalid |=> !rvalid) else $error("answer too long");
   ctrl_top_a: assert property (rd_at(8'h14) |=> rdata[7:6] == 2'h0) else $error("ctrl top bits");
   fade_top_a: assert property (rd_at(8'h15) |=> rdata[7:5] == 3'h0) else $error("fade top bits");
   flags_top_a: assert property (rd_stb && addr inside {[8'h16:8'h18]} |=> rdata[7:6] == 2'h0)
      else $error("flag top bits");
   unmapped_zero_a: assert property (rd_stb && !(addr inside {[8'h14:8'h18]}) |=> rdata == 8'h00)
      else $error("unmapped read");
   interval_legal_a: assert property (wr_stb && addr == 8'h15 |-> wdata[2:0] <= 3'h5)
      else $error("bad interval");
   strobe_excl_a: assert property (wr_stb |-> !rd_stb) else $error("both strobes");
endmodule

//--- led_channel_ctrl_diag_regs_tb.sv
`timescale 1ns/10ps
module led_channel_ctrl_diag_regs_tb;
   logic core_clk = 0, reset_n = 0, req_valid = 0, req_write = 0, global_run = 0, dim_cycle = 0;
   logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, d, r;
   logic [5:0] lowdim_in = 6'h00, open_evt = 6'h00, gnd_short_evt = 6'h00, sink_on;
   logic series_switch_gate, shutdown, fade_en, fade_tick, req_ready, resp_valid, req_refused;
   logic [1:0] fade_step;
   logic [7:0] resp_data;
   logic [7:0] exp_q[$];
   int n_fail = 0, compares = 0, cyc = 0, n_ref = 0, n_tick = 0;
   always #10 core_clk = ~core_clk;
   lcd_if bus_i();
   lcd_dev u_lcd_dev(.core_clk(core_clk), .reset_n(reset_n), .bus(bus_i), .global_run(global_run),
      .dim_cycle(dim_cycle), .lowdim_in(lowdim_in), .open_evt(open_evt), .gnd_short_evt(gnd_short_evt),
      .series_switch_gate(series_switch_gate), .sink_on(sink_on), .shutdown(shutdown), .fade_en(fade_en),
      .fade_step(fade_step), .fade_tick(fade_tick));
   lcd_host u_lcd_host(.core_clk(core_clk), .reset_n(reset_n), .bus(bus_i), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .global_run(global_run),
      .req_ready(req_ready), .resp_data(resp_data), .resp_valid(resp_valid), .req_refused(req_refused));
   lcd_properties u_lcd_properties(.core_clk(core_clk), .reset_n(reset_n), .wr_stb(bus_i.wr_stb),
      .rd_stb(bus_i.rd_stb), .addr(bus_i.addr), .wdata(bus_i.wdata), .rdata(bus_i.rdata), .rvalid(bus_i.rvalid));
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         n_fail++;
         $display("ERROR %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic req(input logic w, input logic [7:0] a, input logic [7:0] v);
      while (req_ready !== 1'b1) @(posedge core_clk) #1;
      {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, v};
      @(posedge core_clk) #1;
      req_valid = 0;
      repeat (4) @(posedge core_clk) #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      req(1'b0, a, 8'h00);
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (resp_valid === 1'b1) chk(resp_data, exp_q.size() ? exp_q.pop_front() : 8'hEE);
      if (req_refused === 1'b1) n_ref++;
      if (fade_tick === 1'b1) n_tick++;
      if (cyc == 6000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(32'h12cdd6f1));
      repeat (5) @(posedge core_clk);
      #1 reset_n = 1;
      chk({series_switch_gate, shutdown, sink_on}, 8'hBF);
      repeat (4) begin
         d = 8'($urandom);
         req(1'b1, 8'h14, d);
         chk({2'h0, sink_on}, {2'h0, ~d[4:0], 1'b1});
         chk({7'h0, series_switch_gate}, {7'h0, ~d[5]});
         rd(8'h14, d & 8'h3F);
         d = 8'($urandom);
         d[2:0] = 3'($urandom_range(5));
         req(1'b1, 8'h15, d);
         chk({5'h0, fade_en, fade_step}, {5'h0, d[3], d[4] ? 2'h2 : 2'h1});
         rd(8'h15, d & 8'h1F);
      end
      $display("test ctrl done");
      for (int k = 0; k < 7; k++) begin
         // Pass six runs with fading off, so no tick may appear
         req(1'b1, 8'h15, (k < 6) ? (8'h08 | k[7:0]) : 8'h00);
         n_tick = 0;
         repeat (64) begin
            dim_cycle = 1;
            @(posedge core_clk) #1 dim_cycle = 0;
            @(posedge core_clk) #1;
         end
         chk(n_tick[7:0], (k < 6) ? (8'h40 >> k) : 8'h00);
      end
      $display("test fade done");
      req(1'b1, 8'h14, 8'h20);
      req(1'b1, 8'h15, 8'h06);
      global_run = 1;
      req(1'b1, 8'h14, 8'h00);
      global_run = 0;
      chk(n_ref[7:0], 8'h02);
      chk({series_switch_gate, shutdown, sink_on}, 8'h3F);
      rd(8'h15, 8'h00);
      lowdim_in = 6'($urandom);
      rd(8'h16, {2'h0, lowdim_in});
      r = 8'($urandom);
      {open_evt, gnd_short_evt} = {r[5:0], ~r[5:0]};
      @(posedge core_clk) #1 {open_evt, gnd_short_evt} = 12'h000;
      rd(8'h17, r & 8'h3F);
      rd(8'h17, 8'h00);
      rd(8'h18, ~r & 8'h3F);
      rd(8'h18, 8'h00);
      rd(8'h19, 8'h00);
      $display("test status done");
      // Run starts just after the host takes the pump-on write
      {req_valid, req_write, req_addr, req_wdata} = {1'b1, 1'b1, 8'h14, 8'h00};
      @(posedge core_clk) #1 {req_valid, global_run} = 2'b01;
      repeat (2) @(posedge core_clk) #1;
      chk({series_switch_gate, shutdown, sink_on}, 8'h40);
      global_run = 0;
      reset_n = 0;
      repeat (2) @(posedge core_clk) #1;
      reset_n = 1;
      chk({series_switch_gate, shutdown, sink_on}, 8'hBF);
      rd(8'h14, 8'h00);
      $display("test shutdown done");
      wrap_up();
   end
endmodule
